/* bench/charge_time_sva.sv */
// Assertions on the register link between the host end and the device end.
`timescale 1ns/10ps
`default_nettype none
module charge_time_sva
    import charge_time_pkg::*;
(
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Link signals.
    input  wire logic       cmd_valid,
    input  wire logic [7:0] command_byte,
    input  wire logic [7:0] cmd_data,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    logic [2:0] sel_r;
    logic [2:0] sel_nxt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Shadow of the wake select, since only writes on the link may change it.
    always_comb begin
        sel_nxt = sel_r;
        if (cmd_valid && command_byte == {1'b1, ADDR_MODE}) begin
            sel_nxt = cmd_data[MODE_WAKE_HI:MODE_WAKE_LO];
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) sel_r <= WAKE_SEL_RESET;
        else sel_r <= sel_nxt;
    end
    AST_READ_ANSWER: assert property (cmd_valid && !command_byte[7] |=> rd_valid)
        else $error("read got no answer");
    AST_NO_STRAY: assert property (rd_valid |-> $past(cmd_valid & ~command_byte[7]))
        else $error("answer without read");
    AST_ONE_CYCLE: assert property (rd_valid && !cmd_valid |=> !rd_valid)
        else $error("answer too long");
    AST_MODE_BIT0: assert property (rd_valid && $past(command_byte[6:0]) == ADDR_MODE
        |-> !rd_data[0]) else $error("mode bit0 set");
    AST_WAKE_ECHO: assert property (rd_valid && $past(command_byte[6:0]) == ADDR_MODE
        |-> rd_data[3:1] == sel_r && sel_r != 3'h0) else $error("wake select wrong");
    AST_CLEAR_DONE: assert property (rd_valid && $past(command_byte[6:0]) == ADDR_TEMP_CLEAR
        && !$past(cmd_valid && command_byte[7], 2) |-> rd_data[4:0] == 5'h00)
        else $error("clear bit stuck");
    AST_CLEAR_SEEN: assert property (rd_valid && $past(command_byte, 2) == {1'b1, ADDR_TEMP_CLEAR}
        && $past(cmd_valid, 2) |-> rd_data[4:0] == $past(cmd_data[4:0], 2))
        else $error("clear bit not seen");
    AST_UNMAPPED: assert property (rd_valid && ($past(command_byte[6:0]) < ADDR_OFFSET
        || $past(command_byte[6:0]) > ADDR_DIS_TIME_HI) |-> rd_data == 8'h00)
        else $error("unmapped read not zero");
    COV_MODE: cover property (rd_valid && $past(command_byte[6:0]) == ADDR_MODE);
    COV_OFFSET: cover property (rd_valid && $past(command_byte[6:0]) == ADDR_OFFSET);
    COV_CLEAR: cover property (cmd_valid && command_byte == {1'b1, ADDR_TEMP_CLEAR});
endmodule : charge_time_sva
`default_nettype wire

/* bench/tb_charge_time_and_calibration_regs.sv */
// Self-checking bench for the register bank and its host end.
`timescale 1ns/10ps
`default_nettype none
module tb_charge_time_and_calibration_regs;
    import charge_time_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, hold_pin_low = 1'b0;
    logic req_ready, req_refused, resp_valid, wake_oe, wake_lvl, clr_self, clr_chg, clr_dis;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_wdata = 8'h00, resp_data, got;
    logic signed [15:0] sense = 16'sh0000;
    logic [2:0] tstep = 3'h5;
    int failures = 0, n_checks = 0;
    // Rows: write flag, address, write data, expected read-back.
    logic [23:0] rows [6] = '{24'hf35a5a, 24'hf53b0a, 24'hf6ff00, 24'hf9ff00, 24'h7400a0, 24'h903300};
    serial_reg_if link ();
    // One count slot per clock, so that a full counter rollover fits in the run.
    charge_time_regs #(.TICK_CYCLES(1), .CAL_LEN(8)) i_charge_time_regs (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .link(link), .effective_sense_voltage(sense), .temperature_step(tstep),
        .wake_n_out(wake_lvl), .wake_n_oe(wake_oe), .self_discharge_clear(clr_self),
        .charge_count_clear(clr_chg), .discharge_count_clear(clr_dis));
    charge_time_host i_charge_time_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .req_refused(req_refused), .resp_valid(resp_valid),
        .resp_data(resp_data), .hold_pin_low(hold_pin_low));
    charge_time_sva i_charge_time_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cmd_valid(link.cmd_valid), .command_byte(link.command_byte), .cmd_data(link.cmd_data),
        .rd_valid(link.rd_valid), .rd_data(link.rd_data));
    always #10 sys_clk = ~sys_clk;
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask : chk1
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // One request; keep leaves the strobe up so a following request goes back to back.
    task automatic op(input logic w, input logic [6:0] a, input logic [7:0] d, input logic keep);
        int k;
        for (k = 0; k < 20 && req_ready !== 1'b1; k++) tick(1);
        if (req_ready !== 1'b1) begin
            failures++;
            test_done();
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        tick(1);
        if (!keep) begin
            req_valid = 1'b0;
            tick(1);
        end
        for (k = 0; k < 10 && !w && resp_valid !== 1'b1; k++) tick(1);
        if (!w && resp_valid !== 1'b1) begin
            failures++;
            test_done();
        end
        got = resp_data;
    endtask : op
    initial begin
        tick(12);
        sys_rst = 1'b0;
        op(1'b0, ADDR_MODE, 8'h00, 1'b0);
        chk8(got, 8'h0e);
        for (int i = 0; i < 6; i++) begin
            if (rows[i][23]) op(1'b1, rows[i][22:16], rows[i][15:8], 1'b0);
            op(1'b0, rows[i][22:16], 8'h00, 1'b0);
            chk8(got, rows[i][7:0]);
        end
        $display("register rows done");
        sense = 16'sd769;
        tick(2);
        chk1(wake_oe, 1'b1);
        chk1(wake_lvl, 1'b0);
        sense = 16'sd768;
        tick(2);
        chk1(wake_oe, 1'b0);
        tick(40);
        op(1'b0, ADDR_CHG_TIME_LO, 8'h00, 1'b0);
        chk1(got != 8'h00, 1'b1);
        sense = 16'sd0;
        op(1'b1, ADDR_TEMP_CLEAR, 8'h10, 1'b1);
        op(1'b0, ADDR_TEMP_CLEAR, 8'h00, 1'b0);
        chk8(got, 8'hb0);
        op(1'b0, ADDR_CHG_TIME_LO, 8'h00, 1'b0);
        chk8(got, 8'h00);
        sense = -16'sd768;
        tick(40);
        op(1'b0, ADDR_DIS_TIME_LO, 8'h00, 1'b0);
        chk1(got != 8'h00, 1'b1);
        sense = 16'sd0;
        op(1'b1, ADDR_TEMP_CLEAR, 8'h0c, 1'b0);
        tick(1);
        chk8({5'h00, clr_self, clr_chg, clr_dis}, 8'h04);
        op(1'b0, ADDR_DIS_TIME_LO, 8'h00, 1'b0);
        chk8(got, 8'h00);
        op(1'b0, ADDR_OFFSET, 8'h00, 1'b0);
        chk8(got, 8'h5a);
        $display("counter tests done");
        op(1'b1, ADDR_MODE, 8'h00, 1'b1);
        chk1(req_refused, 1'b1);
        sense = 16'sd100;
        op(1'b1, ADDR_MODE, 8'hc2, 1'b0);
        tick(20);
        op(1'b0, ADDR_MODE, 8'h00, 1'b0);
        chk8(got, 8'h02);
        op(1'b0, ADDR_OFFSET, 8'h00, 1'b0);
        chk8(got, 8'h64);
        sense = -16'sd5;
        op(1'b1, ADDR_MODE, 8'h42, 1'b0);
        tick(20);
        op(1'b0, ADDR_MODE, 8'h00, 1'b0);
        chk8(got, 8'h42);
        hold_pin_low = 1'b1;
        tick(3);
        hold_pin_low = 1'b0;
        tick(20);
        op(1'b0, ADDR_MODE, 8'h00, 1'b0);
        chk8(got, 8'h42);
        hold_pin_low = 1'b1;
        tick(20);
        op(1'b0, ADDR_MODE, 8'h00, 1'b0);
        chk8(got, 8'h02);
        op(1'b0, ADDR_OFFSET, 8'h00, 1'b0);
        chk8(got, 8'hfb);
        $display("calibration tests done");
        sense = 16'sd100;
        op(1'b1, ADDR_TEMP_CLEAR, 8'h10, 1'b0);
        tick(65600);
        op(1'b0, ADDR_MODE, 8'h00, 1'b0);
        chk8(got, 8'h22);
        op(1'b0, ADDR_CHG_TIME_LO, 8'h00, 1'b0);
        chk8(got, 8'h00);
        op(1'b1, ADDR_TEMP_CLEAR, 8'h10, 1'b0);
        op(1'b0, ADDR_MODE, 8'h00, 1'b0);
        chk8(got, 8'h02);
        $display("rollover tests done");
        test_done();
    end
endmodule : tb_charge_time_and_calibration_regs
`default_nettype wire

/* logic/charge_time_host.sv */
// Host end: issues register commands, collects read answers, drives the pin level.
`timescale 1ns/10ps
`default_nettype none
module charge_time_host
    import charge_time_pkg::*;
(
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Register link toward the device.
    serial_reg_if.host_end  link,
    // User request port.
    input  wire logic       req_valid,
    input  wire logic       req_write,
    input  wire logic [6:0] req_addr,
    input  wire logic [7:0] req_wdata,
    output logic            req_ready,
    output logic            req_refused,
    // User answer port.
    output logic            resp_valid,
    output logic [7:0]      resp_data,
    // Pin control: hold the data line low to permit calibration.
    input  wire logic       hold_pin_low
);
    logic       ready_r;
    logic       ready_nxt;
    logic       refused_r;
    logic       refused_nxt;
    logic       resp_valid_r;
    logic       resp_valid_nxt;
    logic [7:0] resp_data_r;
    logic [7:0] resp_data_nxt;
    logic       cmd_valid_r;
    logic       cmd_valid_nxt;
    logic [7:0] command_r;
    logic [7:0] command_nxt;
    logic [7:0] data_r;
    logic [7:0] data_nxt;
    logic       pin_r;
    logic       pin_nxt;
    logic       take;
    logic       bad_sel;
    logic [7:0] wdata;

    // Only one read may be open; writes never wait for an answer.
    always_comb begin
        take    = req_valid & ready_r;
        wdata   = req_wdata;
        bad_sel = 1'b0;
        if (req_write && req_addr == ADDR_MODE) begin
            wdata[MODE_RESERVED_BIT] = 1'b0;
            bad_sel = (req_wdata[MODE_WAKE_HI:MODE_WAKE_LO] == 3'h0);
        end
        refused_nxt    = take & bad_sel;
        cmd_valid_nxt  = take & ~bad_sel;
        command_nxt    = take ? {req_write, req_addr} : command_r;
        data_nxt       = take ? wdata : data_r;
        ready_nxt      = ready_r;
        if (take && !req_write) begin
            ready_nxt = 1'b0;
        end else if (link.rd_valid) begin
            ready_nxt = 1'b1;
        end
        resp_valid_nxt = link.rd_valid;
        resp_data_nxt  = link.rd_valid ? link.rd_data : resp_data_r;
        pin_nxt        = ~hold_pin_low;
    end

    // Registers; the line idles high after reset.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ready_r      <= 1'b1;
            refused_r    <= 1'b0;
            resp_valid_r <= 1'b0;
            resp_data_r  <= 8'h00;
            cmd_valid_r  <= 1'b0;
            command_r    <= 8'h00;
            data_r       <= 8'h00;
            pin_r        <= 1'b1;
        end else begin
            ready_r      <= ready_nxt;
            refused_r    <= refused_nxt;
            resp_valid_r <= resp_valid_nxt;
            resp_data_r  <= resp_data_nxt;
            cmd_valid_r  <= cmd_valid_nxt;
            command_r    <= command_nxt;
            data_r       <= data_nxt;
            pin_r        <= pin_nxt;
        end
    end

    assign req_ready            = ready_r;
    assign req_refused          = refused_r;
    assign resp_valid           = resp_valid_r;
    assign resp_data            = resp_data_r;
    assign link.cmd_valid       = cmd_valid_r;
    assign link.command_byte    = command_r;
    assign link.cmd_data        = data_r;
    assign link.serial_data_pin = pin_r;
endmodule : charge_time_host
`default_nettype wire

/* logic/charge_time_regs.sv */
// Device end: time counters, mode, clear, offset registers and offset calibration.
//
// Summary of operation
// - Discharge time counts 4096 per hour.
// - Charge time counts 4096 per hour.
// - Discharge rollover sets flag, then 16 per hour.
// - Charge rollover sets slow charge flag.
// - Second rollover clears that slow flag.
// - Host clears time counters within 170 days.
// - Calibrate on request, below threshold, pin low/override.
// - Valid calibration end clears override bit.
// - Calibration request bit clears only when done.
// - Slow flags read at bits five and four.
// - Wake driven low above threshold, else released.
// - Wake select resets to all ones.
// - Threshold is 3.84 mV over select value.
// - Host keeps mode bit zero at zero.
// - Temperature step reads in bits seven to five.
// - Clear bit zeroes counter, then returns low.
// - Clear bits map to their counters and flags.
// - Each clear leaves other registers untouched.
// - Offset is signed byte, sign means discharge.
// - Time counters split high/low at adjacent addresses.
// - Pin high without override, or overload, abandons calibration.
// - Command bit seven writes, low bits address.
`timescale 1ns/10ps
`default_nettype none
module charge_time_regs
    import charge_time_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = FAST_TICK_CYCLES,
    parameter int unsigned CAL_LEN     = CAL_CYCLES
) (
    // Clock and reset.
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    // Register link toward the host.
    serial_reg_if.device_end                   link,
    // Sense front end.
    input  wire logic signed [SENSE_WIDTH-1:0] effective_sense_voltage,
    input  wire logic [2:0]                    temperature_step,
    // Open-drain wake output, active low.
    output logic                               wake_n_out,
    output logic                               wake_n_oe,
    // Clear strobes to the accumulation counters kept elsewhere.
    output logic                               self_discharge_clear,
    output logic                               charge_count_clear,
    output logic                               discharge_count_clear
);
    typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} cal_state_e;

    // Registered state and next values.
    logic [COUNT_WIDTH-1:0]    time_cnt_r [2];
    logic [COUNT_WIDTH-1:0]    time_cnt_nxt [2];
    logic [SLOW_DIV_WIDTH-1:0] slow_div_r [2];
    logic [SLOW_DIV_WIDTH-1:0] slow_div_nxt [2];
    logic [1:0]                slow_flag_r;
    logic [1:0]                slow_flag_nxt;
    logic [31:0]               tick_cnt_r;
    logic [31:0]               tick_cnt_nxt;
    logic [31:0]               cal_cnt_r;
    logic [31:0]               cal_cnt_nxt;
    cal_state_e                cal_state_r;
    cal_state_e                cal_state_nxt;
    logic                      override_r;
    logic                      override_nxt;
    logic                      cal_req_r;
    logic                      cal_req_nxt;
    logic [2:0]                wake_sel_r;
    logic [2:0]                wake_sel_nxt;
    logic [7:0]                offset_value_r;
    logic [7:0]                offset_value_nxt;
    logic [CLEAR_WIDTH-1:0]    clear_pend_r;
    logic [CLEAR_WIDTH-1:0]    clear_pend_nxt;
    logic                      wake_oe_r;
    logic                      wake_oe_nxt;
    logic [2:0]                acc_clear_r;
    logic [2:0]                acc_clear_nxt;
    logic                      rd_valid_r;
    logic                      rd_valid_nxt;
    logic [7:0]                rd_data_r;
    logic [7:0]                rd_data_nxt;

    // Combinational helpers.
    logic                      fast_tick;
    logic [1:0]                active;
    logic [1:0]                step;
    logic [COUNT_WIDTH:0]      sum;
    logic                      roll;
    logic [1:0]                clr_time;
    logic signed [SENSE_WIDTH:0] sense_ext;
    logic [SENSE_WIDTH:0]      magnitude;
    logic [PROD_WIDTH-1:0]     product;
    logic                      below_thr;
    logic                      above_thr;
    logic                      wr_hit;
    logic [6:0]                cmd_addr;
    logic [7:0]                measured;

    // Magnitude against threshold: |v| > 3.84 mV / sel is |v| * sel > 3840 uV,
    // which avoids a divider and stays exact.
    always_comb begin
        sense_ext = {effective_sense_voltage[SENSE_WIDTH-1], effective_sense_voltage};
        magnitude = sense_ext[SENSE_WIDTH] ? (SENSE_WIDTH+1)'(-sense_ext)
                                           : (SENSE_WIDTH+1)'(sense_ext);
        product   = PROD_WIDTH'(magnitude) * PROD_WIDTH'(wake_sel_r);
        below_thr = product < PROD_WIDTH'(WAKE_REF_UV);
        above_thr = product > PROD_WIDTH'(WAKE_REF_UV);
        // Saturate the sampled input into the signed offset byte.
        if (effective_sense_voltage > OFFSET_MAX) begin
            measured = OFFSET_MAX[7:0];
        end else if (effective_sense_voltage < OFFSET_MIN) begin
            measured = OFFSET_MIN[7:0];
        end else begin
            measured = effective_sense_voltage[7:0];
        end
    end

    // Next-state logic for counters, flags, calibration and the register port.
    always_comb begin
        time_cnt_nxt     = time_cnt_r;
        slow_div_nxt     = slow_div_r;
        slow_flag_nxt    = slow_flag_r;
        cal_cnt_nxt      = cal_cnt_r;
        cal_state_nxt    = cal_state_r;
        override_nxt     = override_r;
        cal_req_nxt      = cal_req_r;
        wake_sel_nxt     = wake_sel_r;
        offset_value_nxt = offset_value_r;
        step             = 2'b00;
        sum              = '0;
        roll             = 1'b0;
        cmd_addr         = link.command_byte[6:0];
        wr_hit           = link.cmd_valid & link.command_byte[CMD_WRITE_BIT];

        // Hour prescaler producing one fast count slot.
        fast_tick = (tick_cnt_r == TICK_CYCLES - 32'd1);
        tick_cnt_nxt = fast_tick ? 32'd0 : tick_cnt_r + 32'd1;

        active[CHG_IDX] = ~effective_sense_voltage[SENSE_WIDTH-1]
                        & (effective_sense_voltage != '0);
        active[DIS_IDX] = effective_sense_voltage[SENSE_WIDTH-1];
        clr_time[CHG_IDX] = clear_pend_r[CLR_CHG_TIME_BIT];
        clr_time[DIS_IDX] = clear_pend_r[CLR_DIS_TIME_BIT];

        // Both time counters share one recipe; index 0 charge, 1 discharge.
        for (int i = 0; i < 2; i++) begin
            if (active[i] && fast_tick) begin
                if (slow_flag_r[i]) begin
                    // Slow mode takes one of every 256 fast slots.
                    slow_div_nxt[i] = slow_div_r[i] + 8'h01;
                    step[i] = (slow_div_r[i] == SLOW_DIV_LAST);
                end else begin
                    step[i] = 1'b1;
                end
            end
            sum  = {1'b0, time_cnt_r[i]} + (COUNT_WIDTH+1)'(step[i]);
            roll = sum[COUNT_WIDTH];
            time_cnt_nxt[i] = sum[COUNT_WIDTH-1:0];
            if (roll) begin
                slow_flag_nxt[i] = ~slow_flag_r[i];
                slow_div_nxt[i]  = '0;
            end
            if (clr_time[i]) begin
                // Set wins: a rollover in the clearing cycle still raises the flag.
                time_cnt_nxt[i]  = '0;
                slow_div_nxt[i]  = '0;
                slow_flag_nxt[i] = roll & ~slow_flag_r[i];
            end
        end

        // Offset calibration sequencer.
        case (cal_state_r)
            CAL_IDLE: begin
                cal_cnt_nxt = 32'd0;
                if (cal_req_r && below_thr && (!link.serial_data_pin || override_r)) begin
                    cal_state_nxt = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (!cal_req_r || above_thr || (!override_r && link.serial_data_pin)) begin
                    cal_state_nxt = CAL_IDLE;
                end else if (cal_cnt_r == CAL_LEN - 32'd1) begin
                    cal_state_nxt    = CAL_IDLE;
                    offset_value_nxt = measured;
                    cal_req_nxt      = 1'b0;
                    override_nxt     = 1'b0;
                end else begin
                    cal_cnt_nxt = cal_cnt_r + 32'd1;
                end
            end
            default: begin
                cal_state_nxt = CAL_IDLE;
            end
        endcase

        // Host writes come last, so a request written in the finishing cycle survives.
        clear_pend_nxt = '0;
        if (wr_hit) begin
            case (cmd_addr)
                ADDR_MODE: begin
                    override_nxt = link.cmd_data[MODE_OVERRIDE_BIT];
                    cal_req_nxt  = link.cmd_data[MODE_CAL_BIT];
                    wake_sel_nxt = link.cmd_data[MODE_WAKE_HI:MODE_WAKE_LO];
                end
                ADDR_TEMP_CLEAR: begin
                    clear_pend_nxt = link.cmd_data[CLEAR_WIDTH-1:0];
                end
                ADDR_OFFSET: begin
                    offset_value_nxt = link.cmd_data;
                end
                default: begin
                    // Unmapped and read-only addresses ignore writes.
                end
            endcase
        end

        // Accumulation counters live elsewhere; they get a one-cycle strobe.
        acc_clear_nxt = {clear_pend_r[CLR_SELF_BIT], clear_pend_r[CLR_CHG_CNT_BIT],
                         clear_pend_r[CLR_DIS_CNT_BIT]};
        wake_oe_nxt = above_thr;

        // Read port: one answer the cycle after a read command.
        rd_valid_nxt = link.cmd_valid & ~link.command_byte[CMD_WRITE_BIT];
        case (cmd_addr)
            ADDR_OFFSET:      rd_data_nxt = offset_value_r;
            ADDR_TEMP_CLEAR:  rd_data_nxt = {temperature_step, clear_pend_r};
            ADDR_MODE:        rd_data_nxt = {override_r, cal_req_r,
                                             slow_flag_r[CHG_IDX], slow_flag_r[DIS_IDX],
                                             wake_sel_r, 1'b0};
            ADDR_CHG_TIME_LO: rd_data_nxt = time_cnt_r[CHG_IDX][7:0];
            ADDR_CHG_TIME_HI: rd_data_nxt = time_cnt_r[CHG_IDX][15:8];
            ADDR_DIS_TIME_LO: rd_data_nxt = time_cnt_r[DIS_IDX][7:0];
            ADDR_DIS_TIME_HI: rd_data_nxt = time_cnt_r[DIS_IDX][15:8];
            default:          rd_data_nxt = 8'h00;
        endcase
        if (!rd_valid_nxt) begin
            rd_data_nxt = rd_data_r;
        end
    end

    // State registers.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            time_cnt_r     <= '{default: '0};
            slow_div_r     <= '{default: '0};
            slow_flag_r    <= 2'b00;
            tick_cnt_r     <= 32'd0;
            cal_cnt_r      <= 32'd0;
            cal_state_r    <= CAL_IDLE;
            override_r     <= 1'b0;
            cal_req_r      <= 1'b0;
            wake_sel_r     <= WAKE_SEL_RESET;
            offset_value_r <= OFFSET_RESET;
            clear_pend_r   <= '0;
            wake_oe_r      <= 1'b0;
            acc_clear_r    <= 3'h0;
            rd_valid_r     <= 1'b0;
            rd_data_r      <= 8'h00;
        end else begin
            time_cnt_r     <= time_cnt_nxt;
            slow_div_r     <= slow_div_nxt;
            slow_flag_r    <= slow_flag_nxt;
            tick_cnt_r     <= tick_cnt_nxt;
            cal_cnt_r      <= cal_cnt_nxt;
            cal_state_r    <= cal_state_nxt;
            override_r     <= override_nxt;
            cal_req_r      <= cal_req_nxt;
            wake_sel_r     <= wake_sel_nxt;
            offset_value_r <= offset_value_nxt;
            clear_pend_r   <= clear_pend_nxt;
            wake_oe_r      <= wake_oe_nxt;
            acc_clear_r    <= acc_clear_nxt;
            rd_valid_r     <= rd_valid_nxt;
            rd_data_r      <= rd_data_nxt;
        end
    end

    // Outputs; the wake pin only ever sinks, so its value is fixed low.
    assign wake_n_out            = 1'b0;
    assign wake_n_oe             = wake_oe_r;
    assign self_discharge_clear  = acc_clear_r[2];
    assign charge_count_clear    = acc_clear_r[1];
    assign discharge_count_clear = acc_clear_r[0];
    assign link.rd_valid         = rd_valid_r;
    assign link.rd_data          = rd_data_r;
endmodule : charge_time_regs
`default_nettype wire

/* pkg/charge_time_pkg.sv */
// Shared constants for the charge-time and calibration register bank and its host.
package charge_time_pkg;
    // Register addresses carried in the low seven bits of the command byte.
    localparam logic [6:0] ADDR_OFFSET      = 7'h73;
    localparam logic [6:0] ADDR_TEMP_CLEAR  = 7'h74;
    localparam logic [6:0] ADDR_MODE        = 7'h75;
    localparam logic [6:0] ADDR_CHG_TIME_LO = 7'h76;
    localparam logic [6:0] ADDR_CHG_TIME_HI = 7'h77;
    localparam logic [6:0] ADDR_DIS_TIME_LO = 7'h78;
    localparam logic [6:0] ADDR_DIS_TIME_HI = 7'h79;

    // Command byte layout.
    localparam int CMD_WRITE_BIT = 7;

    // Mode and wake-enable register fields.
    localparam int MODE_OVERRIDE_BIT = 7;
    localparam int MODE_CAL_BIT      = 6;
    localparam int MODE_SLOW_CHG_BIT = 5;
    localparam int MODE_SLOW_DIS_BIT = 4;
    localparam int MODE_WAKE_HI      = 3;
    localparam int MODE_WAKE_LO      = 1;
    localparam int MODE_RESERVED_BIT = 0;
    localparam logic [2:0] WAKE_SEL_RESET = 3'h7;

    // Temperature and clear register fields.
    localparam int TEMP_HI          = 7;
    localparam int TEMP_LO          = 5;
    localparam int CLEAR_WIDTH      = 5;
    localparam int CLR_CHG_TIME_BIT = 4;
    localparam int CLR_DIS_TIME_BIT = 3;
    localparam int CLR_SELF_BIT     = 2;
    localparam int CLR_CHG_CNT_BIT  = 1;
    localparam int CLR_DIS_CNT_BIT  = 0;

    // Counter and offset layout.
    localparam int COUNT_WIDTH  = 16;
    localparam int SENSE_WIDTH  = 16;
    localparam int CHG_IDX      = 0;
    localparam int DIS_IDX      = 1;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic signed [SENSE_WIDTH-1:0] OFFSET_MAX = 16'sh007f;
    localparam logic signed [SENSE_WIDTH-1:0] OFFSET_MIN = -16'sh0080;

    // Time base: counts per hour, and the clock that measures them.
    localparam longint CLK_HZ             = 64'd50000000;
    localparam longint SECONDS_PER_HOUR   = 64'd3600;
    localparam longint FAST_RATE_PER_HOUR = 64'd4096;
    localparam longint SLOW_RATE_PER_HOUR = 64'd16;
    localparam int unsigned FAST_TICK_CYCLES =
        32'(CLK_HZ * SECONDS_PER_HOUR / FAST_RATE_PER_HOUR);
    localparam int SLOW_DIV_WIDTH = 8;
    localparam logic [SLOW_DIV_WIDTH-1:0] SLOW_DIV_LAST =
        8'(FAST_RATE_PER_HOUR / SLOW_RATE_PER_HOUR - 64'd1);

    // Wake threshold: reference in microvolts divided by the select value.
    localparam int WAKE_REF_UV = 3840;
    localparam int PROD_WIDTH  = 20;

    // Offset calibration measuring window.
    localparam longint CAL_TIME_US = 64'd1000;
    localparam int unsigned CAL_CYCLES = 32'(CLK_HZ * CAL_TIME_US / 64'd1000000);
endpackage : charge_time_pkg

/* pkg/serial_reg_if.sv */
// Register access link between the host controller and the counter device.
`timescale 1ns/10ps
`default_nettype none
interface serial_reg_if;
    logic       cmd_valid;
    logic [7:0] command_byte;
    logic [7:0] cmd_data;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       serial_data_pin;

    modport device_end (
        input  cmd_valid,
        input  command_byte,
        input  cmd_data,
        input  serial_data_pin,
        output rd_valid,
        output rd_data
    );

    modport host_end (
        output cmd_valid,
        output command_byte,
        output cmd_data,
        output serial_data_pin,
        input  rd_valid,
        input  rd_data
    );
endinterface : serial_reg_if
`default_nettype wire
